// ### rtl/mtdw_sync.sv
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module mtdw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : mtdw_sync

// ### rtl/mtdw_write_port.sv
// Write port, sample registers and converter sequencing of the Tx front end
//
// What this block does
// - Processor writes an 8-bit input-only bus loading sample, control, index
// - Data captured into the chosen register on the strobe rising edge
// - Write only: the bus is never driven, reads only clear the byte toggle
// - Read/write line high means unselected; strobe only clears the byte toggle
// - Selected only with low-active select low and high-active select high
// - Register selects plus stored index decide if control is reached
// - One 12-bit converter shared in time by line and echo channels
// - Line sample converted while conversion clock low, echo while high
// - Line sample-and-hold updated once per conversion clock period
// - Echo sample-and-hold updated once per conversion clock period too
// - Internal sequencing runs from the 1.44 MHz master clock
// - Line attenuation programmable 0 dB to 22 dB in 2 dB steps
// - Aux input routed to filter or attenuator by the routing field
// - Sample in two writes: bits 3..0 on D7..D4, then bits 11..4
// - Byte toggle advances on sample writes, clears on other strobes
// - Index keeps D7..D5, steps on each control access, 011 hits control
// - Attenuation codes 11xx mute; all control bits preset to one
`timescale 1ns/1ps
module mtdw_write_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic [mtdw_pkg::DATA_W-1:0] write_data_bus,
   input wire logic write_strobe_n,
   input wire logic read_write_sel,
   input wire logic select_active_low_n,
   input wire logic select_active_high,
   input wire logic [1:0] register_select_pair,
   input wire logic master_clock,
   input wire logic conversion_clock,
   output logic [mtdw_pkg::SAMPLE_W-1:0] dac_code_reg,
   output logic dac_echo_phase_reg,
   output logic [mtdw_pkg::SAMPLE_W-1:0] line_hold_reg,
   output logic [mtdw_pkg::SAMPLE_W-1:0] echo_hold_reg,
   output logic [mtdw_pkg::DB_W-1:0] atten_db_reg,
   output logic atten_mute_reg,
   output logic aux_to_filter_reg,
   output logic aux_to_atten_reg,
   output logic [mtdw_pkg::INDEX_W-1:0] index_value_reg,
   output logic filter_tick_reg,
   output logic echo_settling_reg
);
   import mtdw_pkg::*;

   localparam int PIN_W = DATA_W + 6;

   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic [1:0] clocks_s;
   logic [DATA_W-1:0] data_s;
   logic strobe_low_s;
   logic rw_s;
   logic cs_low_s;
   logic cs_high_s;
   logic [1:0] rs_s;
   logic master_s;
   logic conv_s;

   logic strobe_low_d_reg;
   logic [DATA_W-1:0] bus_hold_reg;
   logic [1:0] rs_hold_reg;
   logic rw_hold_reg;
   logic cs_low_hold_reg;
   logic cs_high_hold_reg;
   logic byte_toggle_reg;
   logic byte_toggle_next;
   logic [SAMPLE_W-1:0] line_sample_reg;
   logic [SAMPLE_W-1:0] echo_sample_reg;
   logic [INDEX_W-1:0] index_reg;
   logic [DATA_W-1:0] control_reg;
   logic master_d_reg;
   logic conv_d_reg;
   logic [2:0] div_cnt_reg;
   logic [5:0] period_cnt_reg;

   // Pins are asynchronous to clk, so every one goes through two stages.
   // The strobe is inverted first so the reset value 0 means idle.
   assign pins_raw = {write_data_bus, ~write_strobe_n, read_write_sel,
                      select_active_low_n, select_active_high,
                      register_select_pair};

   mtdw_sync #(
      .WIDTH(PIN_W)
   ) u_bus_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   mtdw_sync #(
      .WIDTH(2)
   ) u_clock_sync (
      .clk(clk),
      .rst(rst),
      .async_in({master_clock, conversion_clock}),
      .sync_out(clocks_s)
   );

   // Field split of the synchronised pins
   assign data_s = pins_s[PIN_W-1 -: DATA_W];
   assign strobe_low_s = pins_s[5];
   assign rw_s = pins_s[4];
   assign cs_low_s = pins_s[3];
   assign cs_high_s = pins_s[2];
   assign rs_s = pins_s[1:0];
   assign master_s = clocks_s[1];
   assign conv_s = clocks_s[0];

   // Strobe edge from the synchronised strobe; bus qualification on the held copies
   logic strobe_rise;
   logic chip_selected;
   logic write_ok;
   logic sample_sel;
   logic line_wr;
   logic echo_wr;
   logic index_wr;
   logic ctrl_access;
   logic ctrl_wr;
   assign strobe_rise = strobe_low_d_reg & ~strobe_low_s;
   assign chip_selected = ~cs_low_hold_reg & cs_high_hold_reg;
   assign write_ok = strobe_rise & chip_selected & ~rw_hold_reg;
   assign sample_sel = write_ok & ~rs_hold_reg[SEL_SAMPLE_BIT];
   assign line_wr = write_ok & (rs_hold_reg == SEL_LINE);
   assign echo_wr = write_ok & (rs_hold_reg == SEL_ECHO);
   assign index_wr = write_ok & (rs_hold_reg == SEL_INDEX);
   assign ctrl_access = write_ok & (rs_hold_reg == SEL_CTRL);
   assign ctrl_wr = ctrl_access & (index_reg == IDX_CTRL);

   // Byte toggle: shared by both sample registers
   assign byte_toggle_next = sample_sel ? ~byte_toggle_reg : 1'b0;

   // Bus and selects are held while the strobe is low, so the data used
   // at the rising edge does not depend on hold time after that edge.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         strobe_low_d_reg <= 1'b0;
         bus_hold_reg <= '0;
         rs_hold_reg <= 2'h0;
         rw_hold_reg <= 1'b1;
         cs_low_hold_reg <= 1'b1;
         cs_high_hold_reg <= 1'b0;
      end
      else
      begin
         strobe_low_d_reg <= strobe_low_s;
         if (strobe_low_s)
         begin
            bus_hold_reg <= data_s;
            rs_hold_reg <= rs_s;
            rw_hold_reg <= rw_s;
            cs_low_hold_reg <= cs_low_s;
            cs_high_hold_reg <= cs_high_s;
         end
      end
   end

   // Toggle advances on sample writes, clears on any other strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         byte_toggle_reg <= 1'b0;
      else if (strobe_rise)
         byte_toggle_reg <= byte_toggle_next;
   end

   // Sample registers: low nibble first, high byte second
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         line_sample_reg <= '0;
         echo_sample_reg <= '0;
      end
      else
      begin
         if (line_wr & ~byte_toggle_reg)
            line_sample_reg[LOW_PART_W-1:0] <= bus_hold_reg[NIB_MSB:NIB_LSB];
         if (line_wr & byte_toggle_reg)
            line_sample_reg[SAMPLE_W-1:LOW_PART_W] <= bus_hold_reg;
         if (echo_wr & ~byte_toggle_reg)
            echo_sample_reg[LOW_PART_W-1:0] <= bus_hold_reg[NIB_MSB:NIB_LSB];
         if (echo_wr & byte_toggle_reg)
            echo_sample_reg[SAMPLE_W-1:LOW_PART_W] <= bus_hold_reg;
      end
   end

   // Index steps on every control access, even one that misses control
   always_ff @(posedge clk)
   begin
      if (rst)
         index_reg <= IDX_RESET;
      else if (index_wr)
         index_reg <= bus_hold_reg[IDX_MSB:IDX_LSB];
      else if (ctrl_access)
         index_reg <= index_reg + IDX_STEP;
   end

   // Control preset to all ones keeps the line silent until programmed
   always_ff @(posedge clk)
   begin
      if (rst)
         control_reg <= CTRL_RESET;
      else if (ctrl_wr)
         control_reg <= {bus_hold_reg[ATT_MSB:ATT_LSB], 1'b1,
                         bus_hold_reg[ROUTE_MSB:ROUTE_LSB], 1'b1};
   end

   // Attenuation and routing decode from the control fields
   logic [ATT_W-1:0] att_code;
   logic [1:0] route_code;
   logic att_mute_next;
   logic [DB_W-1:0] att_db_next;
   assign att_code = control_reg[ATT_MSB:ATT_LSB];
   assign route_code = control_reg[ROUTE_MSB:ROUTE_LSB];
   assign att_mute_next = (att_code[ATT_W-1 -: 2] == ATT_MUTE_TOP);
   assign att_db_next = att_mute_next ? DB_MUTE : {att_code, 1'b0};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         atten_db_reg <= DB_MUTE;
         atten_mute_reg <= 1'b1;
         aux_to_filter_reg <= 1'b0;
         aux_to_atten_reg <= 1'b0;
         index_value_reg <= IDX_RESET;
      end
      else
      begin
         atten_db_reg <= att_db_next;
         atten_mute_reg <= att_mute_next;
         aux_to_filter_reg <= (route_code == ROUTE_FILTER);
         aux_to_atten_reg <= (route_code == ROUTE_ATTEN);
         index_value_reg <= index_reg;
      end
   end

   // Conversion clock edges; both holds load on its falling edge, so the
   // processor must not change a sample around that edge.
   logic conv_fall;
   logic conv_rise;
   logic master_rise;
   assign conv_fall = conv_d_reg & ~conv_s;
   assign conv_rise = ~conv_d_reg & conv_s;
   assign master_rise = master_s & ~master_d_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         conv_d_reg <= 1'b0;
         master_d_reg <= 1'b0;
         line_hold_reg <= '0;
         echo_hold_reg <= '0;
      end
      else
      begin
         conv_d_reg <= conv_s;
         master_d_reg <= master_s;
         if (conv_fall)
         begin
            line_hold_reg <= line_sample_reg;
            echo_hold_reg <= echo_sample_reg;
         end
      end
   end

   // Single converter: line code in the low phase, echo in the high phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dac_code_reg <= '0;
         dac_echo_phase_reg <= 1'b0;
      end
      else
      begin
         dac_code_reg <= conv_s ? echo_hold_reg : line_hold_reg;
         dac_echo_phase_reg <= conv_s;
      end
   end

   // Filter tick is master divided by five, realigned on each rising edge
   // of the conversion clock. The master edge that meets a conversion rise
   // ticks too, so locked clocks keep exactly one tick per five edges.
   logic div_wrap;
   logic settle_next;
   assign div_wrap = (div_cnt_reg == FILTER_DIV - 3'h1);
   assign settle_next = (period_cnt_reg >= SETTLE_START) &&
                        (period_cnt_reg < SETTLE_END);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_cnt_reg <= 3'h0;
         period_cnt_reg <= 6'h0;
         filter_tick_reg <= 1'b0;
         echo_settling_reg <= 1'b0;
      end
      else
      begin
         filter_tick_reg <= master_rise & (div_wrap | conv_rise);
         echo_settling_reg <= settle_next;
         if (conv_rise)
         begin
            div_cnt_reg <= 3'h0;
            period_cnt_reg <= 6'h0;
         end
         else if (master_rise)
         begin
            div_cnt_reg <= div_wrap ? 3'h0 : div_cnt_reg + 3'h1;
            if (period_cnt_reg != PERIOD_MAX)
               period_cnt_reg <= period_cnt_reg + 6'h1;
         end
      end
   end

   // The bus is input only; there is no output enable anywhere.

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_blocked;
      strobe_rise && (rw_hold_reg || !chip_selected);
   endsequence

   sequence seq_second_line;
      line_wr && byte_toggle_reg;
   endsequence

   rw_high_ignored_a: assert property (
      strobe_rise && rw_hold_reg |=> $stable(index_reg) &&
         $stable(control_reg) && $stable(line_sample_reg))
      else $error("write taken with read/write high");

   select_gate_a: assert property (
      seq_blocked |=> $stable(echo_sample_reg) && !byte_toggle_reg)
      else $error("unselected strobe changed state");

   toggle_clear_a: assert property (
      strobe_rise && !sample_sel |=> !byte_toggle_reg)
      else $error("byte toggle not cleared");

   toggle_step_a: assert property (
      sample_sel |=> byte_toggle_reg != $past(byte_toggle_reg))
      else $error("byte toggle did not advance");

   high_byte_a: assert property (
      seq_second_line |=> line_sample_reg[SAMPLE_W-1:LOW_PART_W] ==
         $past(bus_hold_reg) && !byte_toggle_reg)
      else $error("second sample byte misplaced");

   index_step_a: assert property (
      ctrl_access |=> index_reg == $past(index_reg) + IDX_STEP)
      else $error("index did not step");

   ctrl_gate_a: assert property (
      ctrl_access && index_reg != IDX_CTRL |=> $stable(control_reg))
      else $error("control written at wrong index");

   hold_load_a: assert property (
      conv_fall |=> line_hold_reg == $past(line_sample_reg) &&
         echo_hold_reg == $past(echo_sample_reg))
      else $error("holds not loaded on falling edge");

   dac_phase_a: assert property (
      !conv_s ##1 !conv_s |=> dac_code_reg == $past(line_hold_reg) &&
         !dac_echo_phase_reg)
      else $error("converter not on line sample in low phase");

   mute_code_a: assert property (
      att_code[ATT_W-1 -: 2] == ATT_MUTE_TOP |=> atten_mute_reg &&
         atten_db_reg == DB_MUTE)
      else $error("mute code not muting");

   route_a: assert property (
      route_code == ROUTE_ATTEN |=> aux_to_atten_reg && !aux_to_filter_reg)
      else $error("aux routing wrong");

   filter_div_a: assert property (
      filter_tick_reg |-> div_cnt_reg == 3'h0 ##1 !filter_tick_reg)
      else $error("filter tick not on divider wrap");
endmodule : mtdw_write_port

// ### shared/mtdw_pkg.sv
// Constants shared by the transmit converter write port
package mtdw_pkg;
   // Bus and sample widths
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 12;
   localparam int INDEX_W = 3;
   localparam int ATT_W = 4;
   localparam int DB_W = 5;
   // Register select codes, pair is {first select, second select}
   localparam logic [1:0] SEL_LINE = 2'h0;
   localparam logic [1:0] SEL_ECHO = 2'h1;
   localparam logic [1:0] SEL_INDEX = 2'h2;
   localparam logic [1:0] SEL_CTRL = 2'h3;
   // Bit of the select pair that marks the sample registers when low
   localparam int SEL_SAMPLE_BIT = 1;
   // Sample byte layout: first write low nibble, second write high byte
   localparam int NIB_MSB = 7;
   localparam int NIB_LSB = 4;
   localparam int LOW_PART_W = 4;
   // Index register field and the one index that reaches control
   localparam int IDX_MSB = 7;
   localparam int IDX_LSB = 5;
   localparam logic [INDEX_W-1:0] IDX_CTRL = 3'h3;
   localparam logic [INDEX_W-1:0] IDX_STEP = 3'h1;
   localparam logic [INDEX_W-1:0] IDX_RESET = 3'h0;
   // Control register fields and power-up preset
   localparam int ATT_MSB = 7;
   localparam int ATT_LSB = 4;
   localparam int UNUSED_HI_BIT = 3;
   localparam int ROUTE_MSB = 2;
   localparam int ROUTE_LSB = 1;
   localparam int UNUSED_LO_BIT = 0;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'hFF;
   localparam logic [1:0] ROUTE_FILTER = 2'h1;
   localparam logic [1:0] ROUTE_ATTEN = 2'h2;
   localparam logic [1:0] ATT_MUTE_TOP = 2'h3;
   localparam logic [DB_W-1:0] DB_MUTE = 5'h1F;
   // Sequencing clock figures
   localparam int MASTER_CLK_KHZ = 1440;
   localparam int SYS_CLK_KHZ = 40000;
   localparam int MASTER_MIN_CYC = SYS_CLK_KHZ / MASTER_CLK_KHZ / 2;
   localparam logic [2:0] FILTER_DIV = 3'h5;
   localparam logic [5:0] SETTLE_START = 6'h18;
   localparam logic [5:0] SETTLE_END = 6'h1F;
   localparam logic [5:0] PERIOD_MAX = 6'h3F;
endpackage : mtdw_pkg

// ### verification/modem_tx_dac_host_write_port_tb.sv
// Self-checking bench for the Tx front end write port
`timescale 1ns/1ps
module modem_tx_dac_host_write_port_tb;
   import mtdw_pkg::*;
   logic clk, rst, master_clock, conversion_clock;
   logic [DATA_W-1:0] write_data_bus;
   logic write_strobe_n, read_write_sel, select_active_low_n;
   logic select_active_high;
   logic [1:0] register_select_pair;
   logic [SAMPLE_W-1:0] dac_code_reg, line_hold_reg, echo_hold_reg;
   logic dac_echo_phase_reg, atten_mute_reg, aux_to_filter_reg;
   logic aux_to_atten_reg, filter_tick_reg, echo_settling_reg;
   logic [DB_W-1:0] atten_db_reg;
   logic [INDEX_W-1:0] index_value_reg;
   int num_errors, compares, mcnt, tick_cnt, settle_cnt;
   logic [SAMPLE_W-1:0] a, b, c;
   logic [ATT_W-1:0] code;
   logic [DATA_W-1:0] d;

   mtdw_proc_model proc (.clk(clk), .write_data_bus(write_data_bus),
      .write_strobe_n(write_strobe_n), .read_write_sel(read_write_sel),
      .select_active_low_n(select_active_low_n),
      .select_active_high(select_active_high),
      .register_select_pair(register_select_pair));

   mtdw_write_port uut (.clk(clk), .rst(rst),
      .write_data_bus(write_data_bus), .write_strobe_n(write_strobe_n),
      .read_write_sel(read_write_sel),
      .select_active_low_n(select_active_low_n),
      .select_active_high(select_active_high),
      .register_select_pair(register_select_pair),
      .master_clock(master_clock), .conversion_clock(conversion_clock),
      .dac_code_reg(dac_code_reg), .dac_echo_phase_reg(dac_echo_phase_reg),
      .line_hold_reg(line_hold_reg), .echo_hold_reg(echo_hold_reg),
      .atten_db_reg(atten_db_reg), .atten_mute_reg(atten_mute_reg),
      .aux_to_filter_reg(aux_to_filter_reg),
      .aux_to_atten_reg(aux_to_atten_reg),
      .index_value_reg(index_value_reg),
      .filter_tick_reg(filter_tick_reg),
      .echo_settling_reg(echo_settling_reg));

   // System clock, 40 MHz
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Master sequencing clock, 1.44 MHz, unrelated in phase to clk
   initial
   begin
      master_clock = 1'b0;
      #3.1;
      forever #347.222 master_clock = ~master_clock;
   end

   // Conversion clock is master divided by 80, a multiple of five
   initial conversion_clock = 1'b0;
   initial mcnt = 0;
   always @(posedge master_clock)
   begin
      mcnt = (mcnt == 39) ? 0 : mcnt + 1;
      if (mcnt == 0)
         conversion_clock = ~conversion_clock;
   end

   // Pulse and window counters for the sequencing check
   always @(posedge clk)
   begin
      if (filter_tick_reg === 1'b1)
         tick_cnt++;
      if (echo_settling_reg === 1'b1)
         settle_cnt++;
   end

   function automatic logic [DB_W-1:0] exp_db(input logic [ATT_W-1:0] k);
      return (k[3:2] == ATT_MUTE_TOP) ? DB_MUTE : DB_W'({k, 1'b0});
   endfunction : exp_db

   task automatic summarize();
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic chk_val(input string name, input logic [11:0] exp,
      input logic [11:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   // Bounded wait for the conversion clock to move into a level, then let syncs settle
   task automatic wait_conv(input logic lvl);
      int n;
      n = 0;
      while (conversion_clock === lvl && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      while (conversion_clock !== lvl && n < 6000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 6000)
      begin
         num_errors++;
         $display("BAD conv_wait expected edge seen none");
         summarize();
      end
      repeat (8) @(negedge clk);
   endtask : wait_conv

   initial
   begin
      num_errors = 0;
      compares = 0;
      tick_cnt = 0;
      settle_cnt = 0;
      a = 12'($urandom(38));
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      // Power-up state: control preset all ones means muted
      chk_val("mute", 12'h1, 12'(atten_mute_reg));
      chk_val("atten_db", 12'(DB_MUTE), 12'(atten_db_reg));
      chk_val("aux", 12'h0,
         12'({aux_to_filter_reg, aux_to_atten_reg}));
      chk_val("index", 12'h0, 12'(index_value_reg));
      chk_val("line_hold", 12'h0, line_hold_reg);
      // Samples with stray nibbles and refused strobes among them
      for (int r = 0; r < 3; r++)
      begin
         wait_conv(1'b0);
         a = 12'($urandom);
         b = 12'($urandom);
         c = (r == 0) ? 12'h800 : 12'($urandom);
         proc.write_byte(SEL_LINE, 8'(~a), 1'b0, 1'b0, 1'b1);
         proc.write_byte(SEL_INDEX, 8'($urandom), 1'b0, 1'b0, 1'b1);
         proc.write_sample(SEL_LINE, a, 1'b0, 1'b0, 1'b1);
         proc.write_sample(SEL_LINE, b, r == 0, r == 1, r != 2);
         proc.write_sample(SEL_ECHO, c, 1'b0, 1'b0, 1'b1);
         wait_conv(1'b1);
         wait_conv(1'b0);
         chk_val("line_hold", a, line_hold_reg);
         chk_val("echo_hold", c, echo_hold_reg);
         chk_val("dac_low", a, dac_code_reg);
         chk_val("phase_low", 12'h0, 12'(dac_echo_phase_reg));
         wait_conv(1'b1);
         chk_val("dac_high", c, dac_code_reg);
         chk_val("phase_high", 12'h1, 12'(dac_echo_phase_reg));
      end
      // Every attenuation code and route, plus a miss on index four
      for (int k = 0; k < 16; k++)
      begin
         code = 4'(k);
         d = {code, 1'($urandom), code[1:0], 1'($urandom)};
         // Random low bits only; bits 7..5 must stay 011 to reach control
         proc.write_byte(SEL_INDEX, 8'h60 | (8'($urandom) & 8'h1F),
            1'b0, 1'b0, 1'b1);
         chk_val("index_set", 12'(IDX_CTRL), 12'(index_value_reg));
         proc.write_byte(SEL_CTRL, d, 1'b0, 1'b0, 1'b1);
         chk_val("atten_db", 12'(exp_db(code)),
            12'(atten_db_reg));
         chk_val("mute", 12'(code[3:2] == 2'h3), 12'(atten_mute_reg));
         chk_val("to_filter", 12'(code[1:0] == ROUTE_FILTER),
            12'(aux_to_filter_reg));
         chk_val("to_atten", 12'(code[1:0] == ROUTE_ATTEN),
            12'(aux_to_atten_reg));
         chk_val("index_step", 12'h4, 12'(index_value_reg));
         proc.write_byte(SEL_CTRL, ~d, 1'b0, 1'b0, 1'b1);
         chk_val("atten_kept", 12'(exp_db(code)),
            12'(atten_db_reg));
         chk_val("index_step2", 12'h5, 12'(index_value_reg));
      end
      // One conversion period: 80 master periods give 16 filter ticks
      wait_conv(1'b1);
      tick_cnt = 0;
      settle_cnt = 0;
      wait_conv(1'b0);
      wait_conv(1'b1);
      chk_val("filter_ticks", 12'd16, 12'(tick_cnt));
      chk_val("settle_ok", 12'h1,
         12'(settle_cnt >= 190 && settle_cnt <= 200));
      summarize();
   end
endmodule : modem_tx_dac_host_write_port_tb

// ### verification/mtdw_proc_model.sv
// Signal processor model driving the write-only bus of the Tx front end
`timescale 1ns/1ps
module mtdw_proc_model (
   input wire logic clk,
   output logic [mtdw_pkg::DATA_W-1:0] write_data_bus,
   output logic write_strobe_n,
   output logic read_write_sel,
   output logic select_active_low_n,
   output logic select_active_high,
   output logic [1:0] register_select_pair
);
   import mtdw_pkg::*;

   // Bus parked idle: unselected, strobe high
   initial
   begin
      write_data_bus = 8'h00;
      write_strobe_n = 1'b1;
      read_write_sel = 1'b1;
      select_active_low_n = 1'b1;
      select_active_high = 1'b0;
      register_select_pair = 2'h0;
   end

   // One strobe; selects and data stay put across the whole pulse
   task automatic write_byte(input logic [1:0] rs,
      input logic [DATA_W-1:0] data, input logic rw, input logic csn,
      input logic cs);
      @(negedge clk);
      read_write_sel = rw;
      select_active_low_n = csn;
      select_active_high = cs;
      register_select_pair = rs;
      write_data_bus = data;
      write_strobe_n = 1'b0;
      repeat (4) @(negedge clk);
      write_strobe_n = 1'b1;
      // Hold past the rising edge, the port copies the pins late
      repeat (4) @(negedge clk);
      // Released bus shows garbage, not the last value
      write_data_bus = ~data;
      read_write_sel = 1'b1;
      select_active_low_n = 1'b1;
      select_active_high = 1'b0;
      repeat (2) @(negedge clk);
   endtask : write_byte

   // A 12-bit sample goes as low nibble first, then the high byte
   task automatic write_sample(input logic [1:0] rs,
      input logic [SAMPLE_W-1:0] v, input logic rw, input logic csn,
      input logic cs);
      write_byte(rs, {v[3:0], 4'(~v[3:0])}, rw, csn, cs);
      write_byte(rs, v[11:4], rw, csn, cs);
   endtask : write_sample
endmodule : mtdw_proc_model
